// >>> rtl/fsp_ctl.sv
// Purpose: Controller end issuing mode register commands and set point switches
// Assumes: Device end on the same clock
// Notes:   Shadows reference voltage per copy to pick the wait length
`timescale 1ns/1ns
`include "fsp_defines.svh"
module fsp_ctl (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    fsp_if.ctl               link,
    input  wire logic        i_wr_req,
    input  wire logic        i_rd_req,
    input  wire logic [5:0]  i_addr,
    input  wire logic [7:0]  i_data,
    input  wire logic        i_switch_req,
    input  wire logic        i_clk_stop_req,
    output logic             o_ready,
    output logic             o_rd_valid,
    output logic [7:0]       o_rd_data
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RESTORE, ST_GUARD} fsp_ctl_state_e;

    fsp_ctl_state_e st_q;
    logic [7:0]     ctl_q;
    logic [7:0]     vref_q [2];
    logic [7:0]     cnt_q;
    logic           mrw_q;
    logic           mrr_q;
    logic [5:0]     ma_q;
    logic [7:0]     op_q;
    logic           rd_valid_q;
    logic [7:0]     rd_data_q;
    logic           idle;

    assign idle    = (st_q == ST_IDLE);
    assign o_ready = idle;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q  <= ST_IDLE;
            cnt_q <= 8'h00;
            mrw_q <= 1'b0;
            mrr_q <= 1'b0;
            ma_q  <= 6'h00;
            op_q  <= 8'h00;
            ctl_q <= `FSP_RST_CTRL;
        end else begin
            mrw_q <= 1'b0;
            mrr_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (i_switch_req) begin
                        // Flip operating copy and raise fast vref in one write
                        ma_q  <= `FSP_MA_CTRL;
                        op_q  <= ctl_q ^ 8'((1 << `FSP_CTL_OP_BIT)) | 8'((1 << `FSP_CTL_VREF_CURRENT_MODE_BIT));
                        ctl_q <= ctl_q ^ 8'((1 << `FSP_CTL_OP_BIT)) | 8'((1 << `FSP_CTL_VREF_CURRENT_MODE_BIT));
                        mrw_q <= 1'b1;
                        cnt_q <= fsp_pkg::fsp_cycles(fsp_pkg::fsp_case(vref_q[0], vref_q[1]));
                        st_q  <= ST_WAIT;
                    end else if (i_wr_req) begin
                        ma_q  <= i_addr;
                        op_q  <= i_data;
                        mrw_q <= 1'b1;
                        if (i_addr == `FSP_MA_CTRL) begin
                            ctl_q <= i_data;
                        end
                    end else if (i_rd_req) begin
                        ma_q  <= i_addr;
                        mrr_q <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    // Deselect only until the switch time is covered
                    if (cnt_q == 8'h00) begin
                        st_q <= ST_RESTORE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ST_RESTORE: begin
                    ma_q  <= `FSP_MA_CTRL;
                    op_q  <= ctl_q & ~8'((1 << `FSP_CTL_VREF_CURRENT_MODE_BIT));
                    ctl_q <= ctl_q & ~8'((1 << `FSP_CTL_VREF_CURRENT_MODE_BIT));
                    mrw_q <= 1'b1;
                    cnt_q <= 8'(`FSP_CYC_CKV);
                    st_q  <= ST_GUARD;
                end
                ST_GUARD: begin
                    if (cnt_q == 8'h00) begin
                        st_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // Stored vref per copy follows each vref write under the access bit
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            vref_q[0] <= `FSP_RST_CMD_VREF;
            vref_q[1] <= `FSP_RST_CMD_VREF;
        end else if (idle && !i_switch_req && i_wr_req && (i_addr == `FSP_MA_CMD_VREF)) begin
            vref_q[ctl_q[`FSP_CTL_ACC_BIT]] <= i_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= 8'h00;
        end else begin
            rd_valid_q <= link.rd_valid;
            if (link.rd_valid) begin
                rd_data_q <= link.rd_data;
            end
        end
    end

    assign link.mrw      = mrw_q;
    assign link.mrr      = mrr_q;
    assign link.ma       = ma_q;
    assign link.op       = op_q;
    // Clock held valid from every switch command until the guard ends
    assign link.ck_valid = !(idle && !mrw_q && !mrr_q && i_clk_stop_req);
    assign o_rd_valid    = rd_valid_q;
    assign o_rd_data     = rd_data_q;
endmodule : fsp_ctl

// >>> rtl/fsp_defines.svh
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// Mode register addresses
`define FSP_MA_BURST        6'h01
`define FSP_MA_LATENCY      6'h02
`define FSP_MA_IO_DRIVE     6'h03
`define FSP_MA_TERM         6'h0B
`define FSP_MA_CMD_VREF     6'h0C
`define FSP_MA_CTRL         6'h0D
`define FSP_MA_DATA_VREF    6'h0E
`define FSP_MA_RANK_TERM    6'h16

// Set point control fields
`define FSP_CTL_VREF_CURRENT_MODE_BIT    3
`define FSP_CTL_ACC_BIT     6
`define FSP_CTL_OP_BIT      7

// Command reference voltage fields
`define FSP_VREF_SET_MSB    5
`define FSP_VREF_RANGE_BIT  6

// Reset values: unterminated, low-frequency operation
`define FSP_RST_BURST       8'h00
`define FSP_RST_LATENCY     8'h00
`define FSP_RST_IO_DRIVE    8'h31
`define FSP_RST_TERM        8'h00
`define FSP_RST_CMD_VREF    8'h4D
`define FSP_RST_DATA_VREF   8'h4D
`define FSP_RST_RANK_TERM   8'h00
`define FSP_RST_CTRL        8'h00

// Timing, in units as printed
`define FSP_CLK_PS          4000
`define FSP_T_SHORT_NS      200
`define FSP_T_MIDDLE_NS     200
`define FSP_T_LONG_NS       250
`define FSP_T_CKV_PS        7500
`define FSP_T_CKV_NCK       4

// Derived cycle counts, least times rounded up
`define FSP_CYC_SHORT   ((`FSP_T_SHORT_NS * 1000 + `FSP_CLK_PS - 1) / `FSP_CLK_PS)
`define FSP_CYC_MIDDLE  ((`FSP_T_MIDDLE_NS * 1000 + `FSP_CLK_PS - 1) / `FSP_CLK_PS)
`define FSP_CYC_LONG    ((`FSP_T_LONG_NS * 1000 + `FSP_CLK_PS - 1) / `FSP_CLK_PS)
`define FSP_CYC_CKV_NS  ((`FSP_T_CKV_PS + `FSP_CLK_PS - 1) / `FSP_CLK_PS)
`define FSP_CYC_CKV     ((`FSP_CYC_CKV_NS > `FSP_T_CKV_NCK) ? `FSP_CYC_CKV_NS : `FSP_T_CKV_NCK)

`endif

// >>> rtl/fsp_dev.sv
// Purpose: Device end, two copies of frequency dependent mode registers
// Assumes: Controller honours switch time and clock validity
// Notes:   Operating outputs are registered and switch in one edge
`timescale 1ns/1ns
`include "fsp_defines.svh"
module fsp_dev (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    fsp_if.dev                     link,
    output logic [7:0]             o_burst,
    output logic [7:0]             o_latency,
    output logic [7:0]             o_io_drive,
    output logic [7:0]             o_term,
    output logic [7:0]             o_cmd_vref,
    output logic [7:0]             o_data_vref,
    output logic [7:0]             o_rank_term,
    output logic                   o_operating_copy,
    output logic                   o_access_copy,
    output logic                   o_vref_current_mode,
    output logic                   o_switching,
    output fsp_pkg::fsp_case_e     o_switch_case,
    output logic                   o_cmd_refused
);
    localparam fsp_pkg::fsp_bank_t RST_BANK = {
        `FSP_RST_RANK_TERM, `FSP_RST_DATA_VREF, `FSP_RST_CMD_VREF, `FSP_RST_TERM,
        `FSP_RST_IO_DRIVE, `FSP_RST_LATENCY, `FSP_RST_BURST};

    fsp_pkg::fsp_bank_t   bank_q [2];
    fsp_pkg::fsp_bank_t   act_q;
    logic [7:0]           ctl_q;
    logic [7:0]           cnt_q;
    fsp_pkg::fsp_case_e   case_q;
    logic                 rd_valid_q;
    logic [7:0]           rd_data_q;
    logic                 refused_q;
    logic [3:0]           slot;
    logic                 acc_sel;
    logic                 op_sel;
    logic                 busy;
    logic                 cmd_ok;
    logic                 ctl_wr;
    logic                 op_change;
    logic [7:0]           op_sel_d;

    // Decoded command strobes and switch figures
    logic                 wr_hit;
    logic                 rd_hit;
    logic                 refused_d;
    logic [7:0]           rd_mux;
    fsp_pkg::fsp_case_e   sw_case;
    logic [7:0]           sw_cycles;

    assign slot    = fsp_pkg::fsp_slot(link.ma);
    assign acc_sel = ctl_q[`FSP_CTL_ACC_BIT];
    assign op_sel  = ctl_q[`FSP_CTL_OP_BIT];
    assign busy    = (cnt_q != 8'h00);
    // Commands inside the switch window are dropped, not queued
    assign cmd_ok  = !busy;
    assign ctl_wr  = link.mrw && cmd_ok && (link.ma == `FSP_MA_CTRL);
    assign op_sel_d  = ctl_wr ? link.op : ctl_q;
    assign op_change = ctl_wr && (link.op[`FSP_CTL_OP_BIT] != op_sel);
    assign wr_hit    = link.mrw && cmd_ok;
    assign rd_hit    = link.mrr && cmd_ok;
    assign refused_d = busy && (link.mrw || link.mrr);

    // Case is judged from both copies, so either switch direction gives the same wait
    assign sw_case   = fsp_pkg::fsp_case(bank_q[0][4], bank_q[1][4]);
    assign sw_cycles = fsp_pkg::fsp_cycles(sw_case);

    // Control register holds both selectors in separate bits
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctl_q <= `FSP_RST_CTRL;
        end else if (ctl_wr) begin
            ctl_q <= link.op;
        end
    end

    // One write port per copy and slot; a copy is written only when selected
    genvar c;
    genvar r;
    generate
        for (c = 0; c < 2; c++) begin : g_copy
            for (r = 0; r < fsp_pkg::NREG; r++) begin : g_reg
                logic wr_en;
                // Access bit alone picks the copy; the operating bit has no say here
                assign wr_en = wr_hit && (slot == 4'(r)) && (acc_sel == 1'(c));
                always_ff @(posedge i_clk or posedge i_rst) begin
                    if (i_rst) begin
                        bank_q[c][r] <= RST_BANK[r];
                    end else if (wr_en) begin
                        bank_q[c][r] <= link.op;
                    end
                end
            end
        end
    endgenerate

    // Whole copy is loaded in one edge, so no mixed set is ever seen
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            act_q <= RST_BANK;
        end else begin
            act_q <= bank_q[op_sel_d[`FSP_CTL_OP_BIT]];
        end
    end

    // Case is kept for the whole window and after it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            case_q <= fsp_pkg::FSP_CASE_SHORT;
        end else if (op_change) begin
            case_q <= sw_case;
        end
    end

    // Switch window length follows the reference voltage step
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= 8'h00;
        end else if (op_change) begin
            cnt_q <= sw_cycles;
        end else if (busy) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    // Refused command is flagged for one cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            refused_q <= 1'b0;
        end else begin
            refused_q <= refused_d;
        end
    end

    // Reads return the copy under the access bit, or the control register; other addresses read zero
    always_comb begin
        rd_mux = 8'h00;
        if (link.ma == `FSP_MA_CTRL) begin
            rd_mux = ctl_q;
        end else if (slot != 4'hF) begin
            rd_mux = bank_q[acc_sel][slot[2:0]];
        end
    end

    // Answer pulse one cycle after an accepted read
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_hit;
        end
    end

    // Read data is held until the next accepted read
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_data_q <= 8'h00;
        end else if (rd_hit) begin
            rd_data_q <= rd_mux;
        end
    end

    assign link.rd_valid       = rd_valid_q;
    assign link.rd_data        = rd_data_q;

    // Operating image, all from one register so the set never mixes
    assign o_burst             = act_q[0];
    assign o_latency           = act_q[1];
    assign o_io_drive          = act_q[2];
    assign o_term              = act_q[3];
    assign o_cmd_vref          = act_q[4];
    assign o_data_vref         = act_q[5];
    assign o_rank_term         = act_q[6];

    // Selector levels and switch window status
    assign o_operating_copy    = op_sel;
    assign o_access_copy       = acc_sel;
    assign o_vref_current_mode = ctl_q[`FSP_CTL_VREF_CURRENT_MODE_BIT];
    assign o_switching         = busy;
    assign o_switch_case       = case_q;
    assign o_cmd_refused       = refused_q;
endmodule : fsp_dev

// >>> rtl/fsp_if.sv
// Purpose: Mode register command link between controller and device
// Assumes: Both ends on i_clk
// Notes:   Read data returns one cycle after the read command
`timescale 1ns/1ns
interface fsp_if;
    logic       mrw;
    logic       mrr;
    logic [5:0] ma;
    logic [7:0] op;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       ck_valid;

    modport ctl (output mrw, output mrr, output ma, output op, output ck_valid,
                 input rd_valid, input rd_data);
    modport dev (input mrw, input mrr, input ma, input op, input ck_valid,
                 output rd_valid, output rd_data);
endinterface : fsp_if

// >>> rtl/fsp_pkg.sv
// Purpose: Shared types for the set point mode register bank
// Assumes: Constants come from fsp_defines.svh
// Notes:   Seven duplicated registers per copy
`include "fsp_defines.svh"
package fsp_pkg;
    localparam int NREG = 7;

    typedef enum logic [1:0] {
        FSP_CASE_SHORT,
        FSP_CASE_MIDDLE,
        FSP_CASE_LONG
    } fsp_case_e;

    typedef logic [NREG-1:0][7:0] fsp_bank_t;

    // Maps an address onto a copy slot; slot 4'hF when not duplicated
    function automatic logic [3:0] fsp_slot(input logic [5:0] ma);
        logic [3:0] s;
        s = 4'hF;
        case (ma)
            `FSP_MA_BURST:     s = 4'h0;
            `FSP_MA_LATENCY:   s = 4'h1;
            `FSP_MA_IO_DRIVE:  s = 4'h2;
            `FSP_MA_TERM:      s = 4'h3;
            `FSP_MA_CMD_VREF:  s = 4'h4;
            `FSP_MA_DATA_VREF: s = 4'h5;
            `FSP_MA_RANK_TERM: s = 4'h6;
            default:           s = 4'hF;
        endcase
        return s;
    endfunction : fsp_slot

    // Switching case from the two command reference voltage values
    function automatic fsp_case_e fsp_case(input logic [7:0] a, input logic [7:0] b);
        logic [5:0] d;
        fsp_case_e  c;
        d = (a[5:0] > b[5:0]) ? (a[5:0] - b[5:0]) : (b[5:0] - a[5:0]);
        if (a[6] != b[6]) begin
            c = FSP_CASE_LONG;
        end else if (d > 6'h01) begin
            c = FSP_CASE_MIDDLE;
        end else begin
            c = FSP_CASE_SHORT;
        end
        return c;
    endfunction : fsp_case

    function automatic logic [7:0] fsp_cycles(input fsp_case_e c);
        logic [7:0] n;
        case (c)
            FSP_CASE_LONG:   n = 8'(`FSP_CYC_LONG);
            FSP_CASE_MIDDLE: n = 8'(`FSP_CYC_MIDDLE);
            default:         n = 8'(`FSP_CYC_SHORT);
        endcase
        return n;
    endfunction : fsp_cycles
endpackage : fsp_pkg

// >>> verif/fsp_checker.sv
// Purpose: Link checks between controller and device ends
// Assumes: Both ends on i_clk, reset async high
// Notes:   Short and middle switch times share one figure
`timescale 1ns/1ns
`include "fsp_defines.svh"
module fsp_checker (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       mrw,
    input wire logic       mrr,
    input wire logic [5:0] ma,
    input wire logic [7:0] op,
    input wire logic       rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic       ck_valid
);
    localparam int CYC_SHORT = `FSP_CYC_SHORT;
    localparam int CYC_LONG  = `FSP_CYC_LONG;
    localparam int CYC_CKV   = `FSP_CYC_CKV;
    logic [7:0] ctl_q;
    logic [7:0] vref0_q;
    logic [7:0] vref1_q;
    logic [7:0] since_q;
    logic [7:0] need_q;
    logic [3:0] ckv_q;
    wire        cmd = mrw | mrr;
    wire        sw  = mrw && (ma == `FSP_MA_CTRL) && (op[7] != ctl_q[7]);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctl_q <= 8'h00;
        end else if (mrw && ma == `FSP_MA_CTRL) begin
            ctl_q <= op;
        end
    end
    // Shadows pick the wait the device must keep
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            vref0_q <= `FSP_RST_CMD_VREF;
            vref1_q <= `FSP_RST_CMD_VREF;
        end else if (mrw && ma == `FSP_MA_CMD_VREF && ctl_q[6]) begin
            vref1_q <= op;
        end else if (mrw && ma == `FSP_MA_CMD_VREF) begin
            vref0_q <= op;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            since_q <= 8'hFF;
            need_q  <= 8'h00;
        end else if (sw) begin
            since_q <= 8'h00;
            need_q  <= (vref0_q[6] != vref1_q[6]) ? 8'(CYC_LONG) : 8'(CYC_SHORT);
        end else if (since_q != 8'hFF) begin
            since_q <= since_q + 8'h01;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ckv_q <= 4'h0;
        end else begin
            ckv_q <= !ck_valid ? 4'h0 : (ckv_q == 4'hF) ? ckv_q : ckv_q + 4'h1;
        end
    end

    chk_read_answer: assert property (mrr |=> rd_valid)
        else $error("read without answer");
    chk_answer_cause: assert property (rd_valid |-> $past(mrr))
        else $error("answer without read");
    chk_data_holds: assert property (!mrr |=> $stable(rd_data))
        else $error("read data moved");
    chk_fast_vref: assert property (sw |-> op[`FSP_CTL_VREF_CURRENT_MODE_BIT])
        else $error("switch without fast vref");
    chk_switch_quiet: assert property (cmd && !sw |-> since_q >= need_q)
        else $error("command inside switch time");
    chk_vref_current_mode_restore: assert property (mrw && ma == `FSP_MA_CTRL && !op[3] && ctl_q[3]
                                       |-> since_q >= need_q)
        else $error("vref mode restored early");
    chk_clock_after: assert property (sw |-> ck_valid [*5])
        else $error("clock stopped after switch");
    chk_clock_before: assert property (cmd && since_q != 8'hFF |-> ckv_q >= 4'(CYC_CKV))
        else $error("command without valid clock");

    cover property (sw);
    cover property (mrr ##1 rd_valid);
    cover property (sw ##1 need_q == 8'(CYC_LONG));
    cover property (ck_valid ##1 !ck_valid);
endmodule : fsp_checker

// >>> verif/tb_frequency_set_point_mode_regs.sv
// Purpose: Drives the controller user side and watches the device end
// Assumes: Clock 4 ns, reset held 20 cycles
// Notes:   Commands pass the ready handshake only
`timescale 1ns/1ns
`include "fsp_defines.svh"
module tb_frequency_set_point_mode_regs;
    logic               i_clk = 1'b0;
    logic               i_rst = 1'b1;
    logic               i_wr_req = 1'b0;
    logic               i_rd_req = 1'b0;
    logic               i_switch_req = 1'b0;
    logic               i_clk_stop_req = 1'b0;
    logic [5:0]         i_addr = 6'h00;
    logic [7:0]         i_data = 8'h00;
    logic               o_ready;
    logic               o_rd_valid;
    logic [7:0]         o_rd_data;
    logic [7:0]         o_burst, o_latency, o_io_drive, o_term, o_cmd_vref, o_data_vref, o_rank_term;
    logic               o_operating_copy, o_access_copy, o_vref_current_mode, o_switching, o_cmd_refused;
    fsp_pkg::fsp_case_e o_switch_case;
    fsp_pkg::fsp_bank_t outs, rst_v, alt_v, cur;
    logic [5:0]         addr_v [7] = '{6'h01, 6'h02, 6'h03, 6'h0B, 6'h0C, 6'h0E, 6'h16};
    int                 miscompares = 0;
    int                 checks = 0;
    logic               refused_seen = 1'b0;

    assign outs = {o_rank_term, o_data_vref, o_cmd_vref, o_term, o_io_drive, o_latency, o_burst};
    always #2 i_clk = ~i_clk;

    // Controller must never put a command into the switch window
    always @(negedge i_clk) begin
        if (!i_rst && o_cmd_refused !== 1'b0) begin
            refused_seen <= 1'b1;
        end
    end

    fsp_if fsp_if_i ();
    fsp_dev fsp_dev_i (.i_clk(i_clk), .i_rst(i_rst), .link(fsp_if_i), .o_burst(o_burst),
        .o_latency(o_latency), .o_io_drive(o_io_drive), .o_term(o_term), .o_cmd_vref(o_cmd_vref),
        .o_data_vref(o_data_vref), .o_rank_term(o_rank_term), .o_operating_copy(o_operating_copy),
        .o_access_copy(o_access_copy), .o_vref_current_mode(o_vref_current_mode),
        .o_switching(o_switching), .o_switch_case(o_switch_case), .o_cmd_refused(o_cmd_refused));
    fsp_ctl fsp_ctl_i (.i_clk(i_clk), .i_rst(i_rst), .link(fsp_if_i), .i_wr_req(i_wr_req),
        .i_rd_req(i_rd_req), .i_addr(i_addr), .i_data(i_data), .i_switch_req(i_switch_req),
        .i_clk_stop_req(i_clk_stop_req), .o_ready(o_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data));
    fsp_checker fsp_checker_i (.i_clk(i_clk), .i_rst(i_rst), .mrw(fsp_if_i.mrw), .mrr(fsp_if_i.mrr),
        .ma(fsp_if_i.ma), .op(fsp_if_i.op), .rd_valid(fsp_if_i.rd_valid), .rd_data(fsp_if_i.rd_data),
        .ck_valid(fsp_if_i.ck_valid));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    // Waits for ready first so the request is taken at the next edge
    task automatic issue(input logic w, input logic r, input logic s, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge i_clk);
        while (o_ready !== 1'b1 && n < 500) begin
            @(negedge i_clk);
            n++;
        end
        check("ready", {7'h00, o_ready}, 8'h01);
        @(posedge i_clk);
        i_wr_req <= w;
        i_rd_req <= r;
        i_switch_req <= s;
        i_addr <= a;
        i_data <= d;
        @(posedge i_clk);
        i_wr_req <= 1'b0;
        i_rd_req <= 1'b0;
        i_switch_req <= 1'b0;
    endtask : issue

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        int n;
        issue(1'b0, 1'b1, 1'b0, a, 8'h00);
        n = 0;
        while (o_rd_valid !== 1'b1 && n < 8) begin
            @(negedge i_clk);
            n++;
        end
        check("read valid", {7'h00, o_rd_valid}, 8'h01);
        check("read data", o_rd_data, exp);
    endtask : rd

    task automatic chk_bank(input fsp_pkg::fsp_bank_t e);
        for (int i = 0; i < 7; i++) begin
            check("operating reg", outs[i], e[i]);
        end
    endtask : chk_bank

    task automatic sw(input fsp_pkg::fsp_case_e c, input int n_exp, input logic op_exp, input fsp_pkg::fsp_bank_t e);
        int n;
        issue(1'b0, 1'b0, 1'b1, 6'h00, 8'h00);
        n = 0;
        while (o_switching !== 1'b1 && n < 8) begin
            @(negedge i_clk);
            n++;
        end
        chk_bank(e);
        check("operating copy", {7'h00, o_operating_copy}, {7'h00, op_exp});
        check("vref mode", {7'h00, o_vref_current_mode}, 8'h01);
        check("switch case", {6'h00, o_switch_case}, {6'h00, c});
        n = 0;
        while (o_switching === 1'b1 && n < 300) begin
            @(negedge i_clk);
            n++;
        end
        check("switch length", 8'(n), 8'(n_exp));
        issue(1'b0, 1'b1, 1'b0, `FSP_MA_CTRL, 8'h00);
        repeat (3) @(negedge i_clk);
        check("vref mode", {7'h00, o_vref_current_mode}, 8'h00);
        check("read valid", {7'h00, o_rd_valid}, 8'h01);
        check("ctl read vref", {7'h00, o_rd_data[`FSP_CTL_VREF_CURRENT_MODE_BIT]}, 8'h00);
        check("ctl read op", {7'h00, o_rd_data[`FSP_CTL_OP_BIT]}, {7'h00, op_exp});
    endtask : sw

    initial begin
        rst_v = {`FSP_RST_RANK_TERM, `FSP_RST_DATA_VREF, `FSP_RST_CMD_VREF, `FSP_RST_TERM,
                 `FSP_RST_IO_DRIVE, `FSP_RST_LATENCY, `FSP_RST_BURST};
        alt_v = {8'h3F, 8'h7F, 8'h4E, 8'h77, 8'hFB, 8'h7F, 8'hFC};
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        chk_bank(rst_v);
        check("operating copy", {7'h00, o_operating_copy}, 8'h00);
        issue(1'b1, 1'b0, 1'b0, `FSP_MA_CTRL, 8'h40);
        for (int i = 0; i < 7; i++) begin
            issue(1'b1, 1'b0, 1'b0, addr_v[i], alt_v[i]);
        end
        repeat (3) @(negedge i_clk);
        chk_bank(rst_v);
        check("access copy", {7'h00, o_access_copy}, 8'h01);
        check("operating copy", {7'h00, o_operating_copy}, 8'h00);
        for (int i = 0; i < 7; i++) begin
            rd(addr_v[i], alt_v[i]);
        end
        issue(1'b1, 1'b0, 1'b0, 6'h05, 8'hA5);
        rd(6'h05, 8'h00);
        issue(1'b1, 1'b0, 1'b0, `FSP_MA_CTRL, 8'h00);
        for (int i = 0; i < 7; i++) begin
            rd(addr_v[i], rst_v[i]);
        end
        sw(fsp_pkg::FSP_CASE_SHORT, `FSP_CYC_SHORT, 1'b1, alt_v);
        issue(1'b1, 1'b0, 1'b0, `FSP_MA_CMD_VREF, 8'h4B);
        repeat (3) @(negedge i_clk);
        check("cmd vref", o_cmd_vref, 8'h4E);
        cur = rst_v;
        cur[4] = 8'h4B;
        sw(fsp_pkg::FSP_CASE_MIDDLE, `FSP_CYC_MIDDLE, 1'b0, cur);
        issue(1'b1, 1'b0, 1'b0, `FSP_MA_CTRL, 8'h40);
        issue(1'b1, 1'b0, 1'b0, `FSP_MA_CMD_VREF, 8'h0E);
        cur = alt_v;
        cur[4] = 8'h0E;
        sw(fsp_pkg::FSP_CASE_LONG, `FSP_CYC_LONG, 1'b1, cur);
        check("access copy", {7'h00, o_access_copy}, 8'h01);
        rd(`FSP_MA_CTRL, 8'hC0);
        @(posedge i_clk);
        i_clk_stop_req <= 1'b1;
        repeat (3) @(negedge i_clk);
        check("clock valid", {7'h00, fsp_if_i.ck_valid}, 8'h00);
        check("cmd refused", {7'h00, refused_seen}, 8'h00);
        end_sim();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #40000;
        miscompares++;
        end_sim();
    end
endmodule : tb_frequency_set_point_mode_regs
